// File: hdl/bmrs_top.sv
// Battery monitor with processor reset supervisor: flag and reset timing logic.
// Assumes comparator results (1 = above threshold) and a pushbutton input, all asynchronous.
//
// Summary of operation
// R1 - Single-output build asserts the combined flag on a low-level dip and releases it after the high-level input has been above threshold for 150 ms.
// R2 - Dual-output build asserts the weak flag when the high-level input dips and releases it after 150 ms above threshold.
// R3 - Dual-output build asserts the empty flag when the low-level input dips and releases it after 150 ms above threshold.
// R4 - When both levels recover together, the empty flag timeout completes before the weak flag timeout begins.
// R5 - The processor reset output is low whenever the supply is below its reset threshold.
// R6 - After the supply recovers, reset stays low for the whole selected reset timeout.
// R7 - A supply dip during the reset timeout restarts the timeout from zero with reset held low.
// R8 - A manual reset press gives one reset pulse of the selected reset timeout, even with good supplies.
// R9 - The manual reset input is debounced internally over a fixed interval.
// R10 - The reset timeout is a build option of 150 to 300 ms or 1200 to 2400 ms.
// R11 - The reset output is either open-drain or push-pull per build, with the same active-low meaning.
// R12 - The battery outputs are either one combined flag or two separate flags per build.
// R13 - The manual reset pulse starts on the falling edge and is not stretched by holding the input low.
// R14 - Debouncing applies to manual reset rising edges so release bounce gives no new request.
// R15 - All inputs are synchronised and all timeouts are counted in ticks of a free-running time base.
// R16 - A battery dip during a release timeout keeps the flag asserted and restarts its count.
`timescale 1ns/1ps
`default_nettype none
module bmrs_top
    import bmrs_pkg::*;
#(
    parameter logic DUAL_OUTPUT  = 1'b0,
    parameter logic PUSH_PULL    = 1'b0,
    parameter logic LONG_TIMEOUT = 1'b0,
    parameter int   TICK_CYCLES  = TICK_CYCLES_DEF
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic clk_en,
    input  wire logic low_level_compare_in,
    input  wire logic high_level_compare_in,
    input  wire logic supply_compare_in,
    input  wire logic manual_reset_n,
    output logic      battery_low_flag_n,
    output logic      battery_empty_flag_n,
    output logic      battery_weak_flag_n,
    output logic      proc_reset_n_out,
    output logic      proc_reset_oe
);

    localparam bmrs_cnt_type LBO_TICKS   = ms_to_ticks(LBO_TIMEOUT_MS);
    localparam bmrs_cnt_type RESET_TICKS = LONG_TIMEOUT ? ms_to_ticks(LONG_TIMEOUT_MS)
                                                        : ms_to_ticks(SHORT_TIMEOUT_MS); // [R10]
    localparam bmrs_cnt_type DEB_TICKS   = ms_to_ticks(DEBOUNCE_MS);
    localparam int           RESET_MIN_CYC = int'(RESET_TICKS) * TICK_CYCLES;
    localparam int           DEB_MIN_CYC   = int'(DEB_TICKS) * TICK_CYCLES;

    logic               tick_r;
    logic [31:0]        prescale_r;
    logic               low_s;
    logic               high_s;
    logic               supply_s;
    logic               mr_s;
    bmrs_mr_state_type  mr_state_r;
    bmrs_cnt_type       mr_cnt_r;
    logic               mr_pulse_r;
    logic               mr_seen_r;

    bmrs_tmr_if comb_if ();
    bmrs_tmr_if empty_if ();
    bmrs_tmr_if weak_if ();
    bmrs_tmr_if sup_if ();
    bmrs_tmr_if mr_if ();

    // Free-running time base; keeps timing independent of the fast clock
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prescale_r <= '0;
            tick_r     <= 1'b0;
        end else if (clk_en) begin
            if (prescale_r == 32'(TICK_CYCLES - 1)) begin
                prescale_r <= '0;
                tick_r     <= 1'b1;                                  // [R15]
            end else begin
                prescale_r <= prescale_r + 32'h1;
                tick_r     <= 1'b0;
            end
        end
    end

    bmrs_sync #(.W(3), .RST_VAL(CMP_SYNC_RST)) u_cmp_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .ce      (clk_en),
        .d       ({low_level_compare_in, high_level_compare_in, supply_compare_in}),
        .q       ({low_s, high_s, supply_s})                         // [R15]
    );

    bmrs_sync #(.W(1), .RST_VAL(MR_SYNC_RST)) u_mr_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .ce      (clk_en),
        .d       (manual_reset_n),
        .q       (mr_s)
    );

    // Timer hookups
    always_comb begin
        comb_if.tick  = tick_r;
        comb_if.ce    = clk_en;
        comb_if.trip  = !low_s;                                      // [R1]
        comb_if.ok    = high_s;
        comb_if.limit = LBO_TICKS;

        empty_if.tick  = tick_r;
        empty_if.ce    = clk_en;
        empty_if.trip  = !low_s;                                     // [R3]
        empty_if.ok    = low_s;
        empty_if.limit = LBO_TICKS;

        weak_if.tick  = tick_r;
        weak_if.ce    = clk_en;
        weak_if.trip  = !high_s;                                     // [R2]
        // Weak timeout waits for the empty flag to release first
        weak_if.ok    = high_s && !empty_if.active;                  // [R4]
        weak_if.limit = LBO_TICKS;

        sup_if.tick  = tick_r;
        sup_if.ce    = clk_en;
        sup_if.trip  = !supply_s;                                    // [R5] [R7]
        sup_if.ok    = supply_s;
        sup_if.limit = RESET_TICKS;                                  // [R6]

        // Press is taken at once; release must stay high for the debounce time
        mr_if.tick  = tick_r;
        mr_if.ce    = clk_en;
        mr_if.trip  = !mr_s;                                         // [R9]
        mr_if.ok    = mr_s;                                          // [R14]
        mr_if.limit = DEB_TICKS;
    end

    bmrs_release_timer #(.ACTIVE_AT_RESET(1'b1)) u_comb_tmr (
        .clk (clk), .sys_rst (sys_rst), .t (comb_if.timer));
    bmrs_release_timer #(.ACTIVE_AT_RESET(1'b1)) u_empty_tmr (
        .clk (clk), .sys_rst (sys_rst), .t (empty_if.timer));
    bmrs_release_timer #(.ACTIVE_AT_RESET(1'b1)) u_weak_tmr (
        .clk (clk), .sys_rst (sys_rst), .t (weak_if.timer));
    bmrs_release_timer #(.ACTIVE_AT_RESET(1'b1)) u_sup_tmr (
        .clk (clk), .sys_rst (sys_rst), .t (sup_if.timer));
    bmrs_release_timer #(.ACTIVE_AT_RESET(1'b0)) u_mr_tmr (
        .clk (clk), .sys_rst (sys_rst), .t (mr_if.timer));

    // Manual reset one-shot; a held button cannot retrigger until released
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mr_state_r <= MRS_IDLE;
            mr_cnt_r   <= '0;
            mr_pulse_r <= 1'b0;
        end else if (clk_en) begin
            case (mr_state_r)
                MRS_IDLE: begin
                    if (mr_if.active) begin
                        mr_state_r <= MRS_PULSE;                     // [R13]
                        mr_pulse_r <= 1'b1;                          // [R8]
                        mr_cnt_r   <= '0;
                    end
                end
                MRS_PULSE: begin
                    if (tick_r) begin
                        if (mr_cnt_r == RESET_TICKS) begin
                            mr_pulse_r <= 1'b0;
                            mr_cnt_r   <= '0;
                            mr_state_r <= MRS_WAIT_RELEASE;          // [R13]
                        end else begin
                            mr_cnt_r <= mr_cnt_r + bmrs_cnt_type'(1);
                        end
                    end
                end
                MRS_WAIT_RELEASE: begin
                    if (!mr_if.active) begin
                        mr_state_r <= MRS_IDLE;
                    end
                end
                default: begin
                    mr_state_r <= MRS_IDLE;
                    mr_pulse_r <= 1'b0;
                    mr_cnt_r   <= '0;
                end
            endcase
        end
    end

    // Battery flag outputs; unused variant outputs sit released from the first enabled clock after reset
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            battery_low_flag_n   <= FLAG_RST_N;
            battery_empty_flag_n <= FLAG_RST_N;
            battery_weak_flag_n  <= FLAG_RST_N;
        end else if (clk_en) begin
            battery_low_flag_n   <= DUAL_OUTPUT ? 1'b1 : !comb_if.active;  // [R12] [R1]
            battery_empty_flag_n <= DUAL_OUTPUT ? !empty_if.active : 1'b1; // [R3]
            battery_weak_flag_n  <= DUAL_OUTPUT ? !weak_if.active : 1'b1;  // [R2]
        end
    end

    // Processor reset; open-drain only drives while asserting
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            proc_reset_n_out <= PRST_RST_N;
            proc_reset_oe    <= 1'b1;
        end else if (clk_en) begin
            proc_reset_n_out <= !(sup_if.active || mr_pulse_r);            // [R5] [R8]
            proc_reset_oe    <= PUSH_PULL || sup_if.active || mr_pulse_r;  // [R11]
        end
    end

    // Assertion helpers; counters saturate so long runs cannot wrap them
    function automatic logic [31:0] sat_inc(input logic [31:0] v);
        return (v == '1) ? v : v + 32'h1;
    endfunction : sat_inc

    logic [31:0] sup_ok_cyc_r;
    logic [31:0] mr_hi_cyc_r;
    logic        out_live_r;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sup_ok_cyc_r <= '0;
            mr_hi_cyc_r  <= '0;
            mr_seen_r    <= 1'b0;
            out_live_r   <= 1'b0;
        end else if (clk_en) begin
            mr_seen_r    <= mr_if.active;
            out_live_r   <= 1'b1;
            sup_ok_cyc_r <= supply_s ? sat_inc(sup_ok_cyc_r) : '0;
            mr_hi_cyc_r  <= mr_s ? sat_inc(mr_hi_cyc_r) : '0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    AST_SUPPLY_LOW_RESET: assert property ( // [R5]
        (!supply_s && clk_en) [*3] |-> !proc_reset_n_out)
        else $error("reset not asserted with supply low");

    AST_RESET_TIMEOUT: assert property ( // [R6]
        $rose(proc_reset_n_out) |-> sup_ok_cyc_r >= 32'(RESET_MIN_CYC))
        else $error("reset released before the full timeout");

    AST_DIP_HOLDS_RESET: assert property ( // [R7]
        (!supply_s && clk_en) ##1 clk_en |-> (sup_if.cnt == '0) ##1 !proc_reset_n_out)
        else $error("supply dip did not hold reset and restart the count");

    AST_MR_PULSE: assert property ( // [R8]
        (mr_state_r == MRS_IDLE && mr_if.active && clk_en) ##1 clk_en |=> !proc_reset_n_out)
        else $error("manual reset press gave no reset pulse");

    AST_MR_NO_STRETCH: assert property ( // [R13]
        $fell(mr_pulse_r) |-> (mr_state_r == MRS_WAIT_RELEASE && $past(mr_cnt_r) == RESET_TICKS))
        else $error("manual reset pulse length wrong");

    AST_MR_EDGE_ONLY: assert property ( // [R14]
        $rose(mr_pulse_r) |-> (mr_if.active && $past(mr_state_r) == MRS_IDLE))
        else $error("manual reset pulse without a new press");

    AST_EMPTY_BEFORE_WEAK: assert property ( // [R4]
        $rose(battery_weak_flag_n) && DUAL_OUTPUT |-> battery_empty_flag_n && !empty_if.active)
        else $error("weak flag released before empty flag");

    AST_EMPTY_ASSERT: assert property ( // [R3]
        (!low_s && clk_en) [*3] |-> (!battery_empty_flag_n || !DUAL_OUTPUT))
        else $error("empty flag not asserted on low dip");

    AST_COMBINED_ASSERT: assert property ( // [R1]
        (!low_s && clk_en) [*3] |-> (!battery_low_flag_n || DUAL_OUTPUT))
        else $error("combined flag not asserted on low dip");

    AST_WEAK_ASSERT: assert property ( // [R2]
        (!high_s && clk_en) [*3] |-> (!battery_weak_flag_n || !DUAL_OUTPUT))
        else $error("weak flag not asserted on high dip");

    AST_WEAK_WAITS_EMPTY: assert property ( // [R4]
        (clk_en && empty_if.active) |=> (weak_if.cnt == '0))
        else $error("weak timeout ran while empty flag was asserted");

    AST_UNUSED_RELEASED: assert property ( // [R12]
        out_live_r |-> (DUAL_OUTPUT ? battery_low_flag_n
                                    : (battery_empty_flag_n && battery_weak_flag_n)))
        else $error("unused battery output not released");

    AST_OE_MATCH: assert property ( // [R11]
        proc_reset_oe == (PUSH_PULL || !proc_reset_n_out))
        else $error("reset output enable wrong for the drive type");

    AST_MR_ONE_SHOT: assert property ( // [R13]
        $rose(mr_pulse_r) |-> ($past(mr_if.active) && !$past(mr_seen_r)))
        else $error("manual reset pulse started on a held button");

    AST_MR_DEBOUNCE: assert property ( // [R9] [R14]
        $fell(mr_if.active) |-> (mr_hi_cyc_r >= 32'(DEB_MIN_CYC)))
        else $error("button release taken before the debounce interval");

    COV_SUPPLY_RELEASE: cover property ($rose(proc_reset_n_out));
    COV_MR_PULSE:       cover property ($fell(mr_pulse_r));
    COV_EMPTY_RELEASE:  cover property ($rose(battery_empty_flag_n));
    COV_SUPPLY_RESTART: cover property (sup_if.cnt != '0 ##1 !supply_s);
    COV_WEAK_RELEASE:   cover property ($rose(battery_weak_flag_n) && DUAL_OUTPUT);

endmodule : bmrs_top
`default_nettype wire

// File: hdl/bmrs_pkg.sv
// Shared constants, types and helpers for the battery monitor and reset supervisor.
// Assumes a single 200 MHz system clock; all timeouts are counted in slow time-base ticks.
package bmrs_pkg;

    // Clock and time base
    localparam int CLK_PERIOD_PS   = 5000;
    localparam int TICK_PERIOD_US  = 1000;
    localparam int TICK_CYCLES_DEF = (TICK_PERIOD_US * 1000000) / CLK_PERIOD_PS;

    // Timeouts in milliseconds, as minimum durations
    localparam int LBO_TIMEOUT_MS   = 150;
    localparam int SHORT_TIMEOUT_MS = 150;
    localparam int LONG_TIMEOUT_MS  = 1200;
    localparam int DEBOUNCE_MS      = 20;

    localparam int CNT_W = 12;
    typedef logic [CNT_W-1:0] bmrs_cnt_type;

    // Synchroniser idle levels
    localparam logic [2:0] CMP_SYNC_RST = 3'h0;
    localparam logic       MR_SYNC_RST  = 1'b1;

    // Output levels after reset: flags and processor reset asserted
    localparam logic FLAG_RST_N   = 1'b0;
    localparam logic PRST_RST_N   = 1'b0;

    typedef enum logic [1:0] {
        MRS_IDLE,
        MRS_PULSE,
        MRS_WAIT_RELEASE
    } bmrs_mr_state_type;

    // Milliseconds to whole ticks, rounded up
    function automatic bmrs_cnt_type ms_to_ticks(input int ms);
        int ticks;
        ticks = (ms * 1000 + TICK_PERIOD_US - 1) / TICK_PERIOD_US;
        return bmrs_cnt_type'(ticks);
    endfunction : ms_to_ticks

endpackage : bmrs_pkg

// File: hdl/bmrs_tmr_if.sv
// Carrier between the supervisor top and each release timer.
// Assumes one clock domain; owner drives controls, timer returns its flag.
`timescale 1ns/1ps
`default_nettype none
interface bmrs_tmr_if;
    import bmrs_pkg::*;
    logic         tick;
    logic         ce;
    logic         trip;
    logic         ok;
    bmrs_cnt_type limit;
    logic         active;
    bmrs_cnt_type cnt;

    modport timer (input tick, input ce, input trip, input ok, input limit,
                   output active, output cnt);
    modport owner (output tick, output ce, output trip, output ok, output limit,
                   input active, input cnt);
endinterface : bmrs_tmr_if
`default_nettype wire

// File: hdl/bmrs_sync.sv
// Two-stage synchroniser for a group of level inputs.
// Assumes inputs may change at any time relative to clk.
`timescale 1ns/1ps
`default_nettype none
module bmrs_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_r <= RST_VAL;
            q      <= RST_VAL;
        end else if (ce) begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule : bmrs_sync
`default_nettype wire

// File: hdl/bmrs_release_timer.sv
// Asserting flag with a minimum-duration release timeout.
// Trip sets the flag at once; release needs ok held for limit full tick periods.
`timescale 1ns/1ps
`default_nettype none
module bmrs_release_timer
    import bmrs_pkg::*;
#(
    parameter logic ACTIVE_AT_RESET = 1'b1
) (
    input wire logic  clk,
    input wire logic  sys_rst,
    bmrs_tmr_if.timer t
);
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            t.active <= ACTIVE_AT_RESET;
            t.cnt    <= '0;
        end else if (t.ce) begin
            if (t.trip) begin
                t.active <= 1'b1;
                t.cnt    <= '0;
            end else if (!t.ok) begin
                t.cnt    <= '0;                                    // [R16]
            end else if (t.active && t.tick) begin
                // First tick may be partial, so release only after limit+1 ticks
                if (t.cnt == t.limit) begin
                    t.active <= 1'b0;
                    t.cnt    <= '0;
                end else begin
                    t.cnt    <= t.cnt + bmrs_cnt_type'(1);
                end
            end
        end
    end

    AST_RESTART_ON_DIP: assert property (@(posedge clk) disable iff (sys_rst) // [R16]
        (t.ce && t.trip) |=> (t.active && t.cnt == '0))
        else $error("timer did not restart on a dip");

    AST_RELEASE_AT_LIMIT: assert property (@(posedge clk) disable iff (sys_rst) // [R15]
        $fell(t.active) |-> ($past(t.cnt) == $past(t.limit) && $past(t.tick)))
        else $error("flag released before the full count");
endmodule : bmrs_release_timer
`default_nettype wire

// File: sim/bmrs_host_model.sv
// Host side model: resolves the reset pin and measures its low pulses.
// Assumes it sees the supervisor reset level and enable on the same clock.
`timescale 1ns/1ps
`default_nettype none
module bmrs_host_model (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic rst_level,
    input  wire logic rst_oe,
    output logic      pin_n,
    output int        pulses,
    output int        low_len
);
    logic prev_r;

    // A released open-drain pin sits at the board pull-up level
    assign pin_n = rst_oe ? rst_level : 1'b1;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prev_r  <= 1'b0;
            pulses  <= 0;
            low_len <= 0;
        end else begin
            prev_r <= pin_n;
            if (prev_r && !pin_n) begin
                pulses  <= pulses + 1;
                low_len <= 1;
            end else if (!pin_n) begin
                low_len <= low_len + 1;
            end
        end
    end
endmodule : bmrs_host_model
`default_nettype wire

// File: sim/bmrs_top_tb.sv
// Self-checking bench: single/open-drain/short and dual/push-pull/long builds.
// Assumes a shortened time base of T clocks per tick; counts in ticks unchanged.
`timescale 1ns/1ps
`default_nettype none
module bmrs_top_tb;
    import bmrs_pkg::*;
    localparam int T   = 4;
    localparam int NB  = LBO_TIMEOUT_MS * 1000 / TICK_PERIOD_US;
    localparam int NS  = SHORT_TIMEOUT_MS * 1000 / TICK_PERIOD_US;
    localparam int NLG = LONG_TIMEOUT_MS * 1000 / TICK_PERIOD_US;
    localparam int ND  = DEBOUNCE_MS * 1000 / TICK_PERIOD_US;
    logic clk, sys_rst, clk_en, low_in, high_in, supply_in, button_n;
    logic s_low_n, s_emp_n, s_weak_n, s_rst_n, s_oe;
    logic d_low_n, d_emp_n, d_weak_n, d_rst_n, d_oe;
    logic pin_n;
    int   pulses, low_len, cyc, t0, total_checks, mismatches;
    int   rise_t [5];
    wire logic [4:0] watch = {d_rst_n, d_weak_n, d_emp_n, s_low_n, pin_n};

    bmrs_top #(.DUAL_OUTPUT(1'b0), .PUSH_PULL(1'b0), .LONG_TIMEOUT(1'b0), .TICK_CYCLES(T))
    i_dut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .low_level_compare_in(low_in),
        .high_level_compare_in(high_in), .supply_compare_in(supply_in),
        .manual_reset_n(button_n), .battery_low_flag_n(s_low_n),
        .battery_empty_flag_n(s_emp_n), .battery_weak_flag_n(s_weak_n),
        .proc_reset_n_out(s_rst_n), .proc_reset_oe(s_oe));
    bmrs_top #(.DUAL_OUTPUT(1'b1), .PUSH_PULL(1'b1), .LONG_TIMEOUT(1'b1), .TICK_CYCLES(T))
    i_dut2 (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .low_level_compare_in(low_in),
        .high_level_compare_in(high_in), .supply_compare_in(supply_in),
        .manual_reset_n(button_n), .battery_low_flag_n(d_low_n),
        .battery_empty_flag_n(d_emp_n), .battery_weak_flag_n(d_weak_n),
        .proc_reset_n_out(d_rst_n), .proc_reset_oe(d_oe));
    bmrs_host_model i_host (.clk(clk), .sys_rst(sys_rst), .rst_level(s_rst_n),
        .rst_oe(s_oe), .pin_n(pin_n), .pulses(pulses), .low_len(low_len));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // First release time of each watched output, sampled where it is settled
    always @(negedge clk) begin
        cyc++;
        for (int i = 0; i < 5; i++) begin
            if (watch[i] === 1'b1 && rise_t[i] < 0) rise_t[i] = cyc;
        end
    end

    task automatic waitc(input int n);
        repeat (n) @(negedge clk);
    endtask : waitc

    task automatic arm();
        for (int i = 0; i < 5; i++) rise_t[i] = -1;
        t0 = cyc;
    endtask : arm

    task automatic chk_bit(input string name, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %b seen %b", name, exp, got);
        end
    endtask : chk_bit

    task automatic chk_rng(input string name, input int lo, input int hi, input int got);
        total_checks++;
        if (got < lo || got > hi) begin
            mismatches++;
            $display("Error %s expected %0d..%0d seen %0d", name, lo, hi, got);
        end
    endtask : chk_rng

    // Latency slack covers the synchroniser, timer and output flops
    task automatic chk_rel(input string name, input int i, input int n);
        chk_rng(name, n * T, (n + 1) * T + 8, rise_t[i] - t0);
    endtask : chk_rel

    task automatic t_power_up();
        chk_bit("por reset", 1'b0, s_rst_n);
        chk_bit("por empty", 1'b0, d_emp_n);
        chk_bit("unused single flag", 1'b1, d_low_n);
        chk_bit("unused dual flag", 1'b1, s_weak_n);
        @(posedge clk);
        low_in    <= 1'b1;
        high_in   <= 1'b1;
        supply_in <= 1'b1;
        arm();
        waitc((NLG + 2) * T + 20);
        chk_rel("single flag release", 1, NB);
        chk_rel("empty release", 2, NB);
        chk_rng("weak after empty", NB * T, (NB + 1) * T + 8, rise_t[3] - rise_t[2]);
        chk_rel("short reset release", 0, NS);
        chk_rel("long reset release", 4, NLG);
        chk_bit("open drain released", 1'b0, s_oe);
        chk_bit("push pull enable", 1'b1, d_oe);
    endtask : t_power_up

    task automatic t_supply_dip();
        @(posedge clk);
        supply_in <= 1'b0;
        waitc(5);
        chk_bit("reset on dip", 1'b0, pin_n);
        chk_bit("open drain driving", 1'b1, s_oe);
        chk_bit("push pull reset on dip", 1'b0, d_rst_n);
        @(posedge clk);
        supply_in <= 1'b1;
        waitc(NS / 2 * T);
        chk_bit("reset held in timeout", 1'b0, pin_n);
        @(posedge clk);
        supply_in <= 1'b0;
        waitc(3);
        @(posedge clk);
        supply_in <= 1'b1;
        arm();
        waitc((NLG + 2) * T + 20);
        chk_rel("restarted reset release", 0, NS);
        chk_rel("restarted long release", 4, NLG);
    endtask : t_supply_dip

    task automatic t_battery_dip();
        @(posedge clk);
        low_in <= 1'b0;
        waitc(5);
        chk_bit("single flag on dip", 1'b0, s_low_n);
        chk_bit("empty on dip", 1'b0, d_emp_n);
        chk_bit("weak kept", 1'b1, d_weak_n);
        @(posedge clk);
        low_in <= 1'b1;
        waitc(NB / 2 * T);
        @(posedge clk);
        low_in <= 1'b0;
        waitc(2);
        @(posedge clk);
        low_in <= 1'b1;
        arm();
        waitc((NB + 2) * T + 20);
        chk_rel("single flag restarted", 1, NB);
        chk_rel("empty restarted", 2, NB);
        @(posedge clk);
        high_in <= 1'b0;
        waitc(5);
        chk_bit("weak on dip", 1'b0, d_weak_n);
        chk_bit("empty kept", 1'b1, d_emp_n);
        chk_bit("single flag kept", 1'b1, s_low_n);
        @(posedge clk);
        high_in <= 1'b1;
        arm();
        waitc((NB + 2) * T + 20);
        chk_rel("weak release", 3, NB);
    endtask : t_battery_dip

    task automatic t_manual();
        int n0;
        n0 = pulses;
        @(posedge clk);
        button_n <= 1'b0;
        waitc(7);
        chk_bit("pushbutton reset", 1'b0, pin_n);
        chk_bit("pushbutton reset pp", 1'b0, d_rst_n);
        waitc((NS + 2) * T + 20);
        chk_bit("pulse ends while held", 1'b1, pin_n);
        chk_rng("pulse length", NS * T, (NS + 1) * T + 2, low_len);
        // Release bounce far shorter than the debounce interval
        repeat (4) begin
            @(posedge clk);
            button_n <= 1'b1;
            waitc(3);
            @(posedge clk);
            button_n <= 1'b0;
            waitc(3);
        end
        @(posedge clk);
        button_n <= 1'b1;
        waitc((ND + 2) * T + 10);
        chk_rng("pulses after bounce", n0 + 1, n0 + 1, pulses);
        chk_bit("no reset on bounce", 1'b1, pin_n);
        @(posedge clk);
        button_n <= 1'b0;
        waitc(7);
        chk_bit("second press", 1'b0, pin_n);
        chk_rng("pulses after press", n0 + 2, n0 + 2, pulses);
        @(posedge clk);
        button_n <= 1'b1;
        waitc((NS + 2) * T + 20);
        chk_bit("second pulse over", 1'b1, pin_n);
    endtask : t_manual

    // Inputs moved while the enable is low must leave no trace
    task automatic t_freeze();
        @(posedge clk);
        supply_in <= 1'b0;
        waitc(5);
        @(posedge clk);
        supply_in <= 1'b1;
        arm();
        waitc(100);
        @(posedge clk);
        clk_en <= 1'b0;
        low_in <= 1'b0;
        waitc(200);
        @(posedge clk);
        clk_en <= 1'b1;
        low_in <= 1'b1;
        waitc((NS + 2) * T + 20);
        chk_bit("flag ignores frozen dip", 1'b1, s_low_n);
        chk_rng("frozen release", NS * T + 200, NS * T + 212, rise_t[0] - t0);
    endtask : t_freeze

    task automatic finish_test();
        $display("Checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        total_checks = 0;
        mismatches   = 0;
        cyc          = 0;
        sys_rst      = 1'b1;
        clk_en       = 1'b1;
        low_in       = 1'b0;
        high_in      = 1'b0;
        supply_in    = 1'b0;
        button_n     = 1'b1;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        waitc(4);
        t_power_up();
        t_supply_dip();
        t_battery_dip();
        t_manual();
        t_freeze();
        finish_test();
    end

    // About 14000 cycles are expected; twice that means a hang
    initial begin
        repeat (28000) @(posedge clk);
        mismatches++;
        $display("Error watchdog expected done seen hang");
        finish_test();
    end
endmodule : bmrs_top_tb
`default_nettype wire
